/* File: src/sacc_pkg.sv */
// sacc_pkg: constants, state types and carriers of the sampling converter control.
// assumes a single 250 MHz clock; the control uses most constants, the pulse timer only the counter ones and its length.
package sacc_pkg;

	// ==================================================================
	// clock and timing
	localparam int CLK_PERIOD_PS = 4000;	// 4 ns clock period
	localparam int PUP_TIME_US   = 1;	// power-up pulse, 1 us
	localparam int CONV_TIME_NS  = 2300;	// conversion time, 2.3 us

	// least times round up to whole cycles, never below one
	localparam int PUP_CYCLES_C  = ((PUP_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS < 1)
		? 1 : (PUP_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CONV_CYCLES_C = ((CONV_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS < 1)
		? 1 : (CONV_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// ==================================================================
	// widths and field positions
	localparam int RES_W      = 10;	// result width
	localparam int BUS_W      = 8;	// parallel port width
	localparam int LSB_N      = 2;	// low bits returned by the second read
	localparam int CNT_W      = 10;	// width of the cycle counters
	localparam int MSB_LO_POS = 2;	// lowest result bit of the upper byte
	localparam int LSB_PAD_W  = BUS_W - LSB_N;	// zeros below the low bits

	// ==================================================================
	// reset values
	localparam logic [RES_W-1:0] RESULT_RST = 10'h000;
	localparam logic [BUS_W-1:0] DB_RST     = 8'h00;
	localparam logic [CNT_W-1:0] CNT_RST    = 10'h000;

	// ==================================================================
	// types
	typedef enum logic {
		SACC_ST_TRACK,
		SACC_ST_CONV
	} sacc_state_t;

	// pulse timer state
	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic             act;
	} sacc_pls_st_t;

	// read port answer
	typedef struct packed {
		logic [BUS_W-1:0] data;
		logic             oe;
	} sacc_rd_t;

	// control state
	typedef struct packed {
		sacc_state_t      st;
		logic [CNT_W-1:0] conv_cnt;
		logic             ext_q;
		logic             gated_q;
		logic             acc_q;
		logic             powered;
		logic             fast;
		logic             phase;
		logic [RES_W-1:0] result;
		logic [BUS_W-1:0] db;
	} sacc_ctl_st_t;

endpackage

/* File: src/sacc_pulse.sv */
// sacc_pulse: retriggerable power-up pulse timer.
// assumes trig is a one-cycle pulse in the CLK domain.
`timescale 1ns/1ps
module sacc_pulse
	import sacc_pkg::*;
#(
	parameter int LEN = PUP_CYCLES_C
) (
	// clock and reset
	input  wire logic CLK,
	input  wire logic RST,
	// trigger and pulse
	input  wire logic trig,
	output logic      act
);

	// ==================================================================
	// elaboration check
	generate
		if (LEN < 1 || LEN >= (1 << CNT_W)) begin : g_bad_len
			$error("sacc_pulse: LEN out of range");
		end
	endgenerate

	localparam logic [CNT_W-1:0] LEN_C = CNT_W'(LEN);

	sacc_pls_st_t s_q;
	sacc_pls_st_t s_d;

	// ==================================================================
	// counter: a new trigger restarts the full length, so a short high
	// glitch on the start pin still buys a whole power-up time
	always_comb begin
		s_d = s_q;
		if (trig) begin
			s_d.cnt = LEN_C;
		end else if (s_q.cnt != CNT_RST) begin
			s_d.cnt = s_q.cnt - 10'h001;
		end
		s_d.act = trig || (s_q.cnt > 10'h001);
	end

	// state register
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign act = s_q.act;

endmodule

/* File: src/sacc_ctrl.sv */
// sacc_ctrl: conversion control and two-read result port of a 10-bit sampling converter.
// assumes all pins are synchronous to CLK; the sampler supplies a settled code on SAR_CODE
// when the conversion time has run out.
//
// Behaviour
// - start rising edge fires 1 us pulse
// - start low at pulse end: convert then
// - start high at pulse end: convert on its fall
// - gated start is start OR pulse
// - busy high throughout conversion
// - end: track, busy low, latch result
// - two reads: upper eight, then low two
// - start high at busy fall: stay powered
// - start low at busy fall: power down
// - read port works while powered down
// - data driven only while select and strobe low
// - low read: bits on 7,6, rest zero
// - further reads keep alternating
// - busy rising resets read phase
// - conversion lasts 2.3 us
// - after reset powered down until rising start
// - straight binary result coding
`timescale 1ns/1ps
module sacc_ctrl
	import sacc_pkg::*;
#(
	parameter int CONV_CYCLES = CONV_CYCLES_C,
	parameter int PUP_CYCLES  = PUP_CYCLES_C
) (
	// clock and reset
	input  wire logic             CLK,
	input  wire logic             RST,
	// conversion control
	input  wire logic             CONVERT_START_N,
	output logic                  BUSY,
	output logic                  HOLD,
	output logic                  POWERED,
	output logic                  FAST_MODE,
	// sampler code
	input  wire logic [RES_W-1:0] SAR_CODE,
	// parallel read port
	input  wire logic             CS_N,
	input  wire logic             RD_N,
	output logic      [BUS_W-1:0] DB_O,
	output logic                  DB_OE
);

	// ==================================================================
	// elaboration check
	generate
		if (CONV_CYCLES < 2 || CONV_CYCLES >= (1 << CNT_W)) begin : g_bad_conv
			$error("sacc_ctrl: CONV_CYCLES out of range");
		end
	endgenerate

	localparam logic [CNT_W-1:0] CONV_LAST_C = CNT_W'(CONV_CYCLES - 1);

	sacc_ctl_st_t s_q;
	sacc_ctl_st_t s_d;
	sacc_rd_t     rd;
	logic         pls_act;
	logic         start_rise;
	logic         gated;
	logic         gated_fall;
	logic         access;
	logic         read_end;
	logic         conv_done;

	// ==================================================================
	// power-up pulse timer
	sacc_pulse #(
		.LEN (PUP_CYCLES)
	) u_pulse (
		.CLK  (CLK),
		.RST  (RST),
		.trig (start_rise),
		.act  (pls_act)
	);

	// ==================================================================
	// edge detection on the start pin and the gated start
	assign start_rise = CONVERT_START_N && !s_q.ext_q;
	// the longer of pin level and pulse decides when sampling stops
	assign gated      = CONVERT_START_N || pls_act;
	assign gated_fall = s_q.gated_q && !gated;
	assign conv_done  = (s_q.st == SACC_ST_CONV) && (s_q.conv_cnt == CNT_RST);

	// read strobe: a read ends when select or strobe goes high
	assign access   = !CS_N && !RD_N;
	assign read_end = s_q.acc_q && !access;

	// ==================================================================
	// next-state logic
	always_comb begin
		s_d         = s_q;
		s_d.ext_q   = CONVERT_START_N;
		s_d.gated_q = gated;
		s_d.acc_q   = access;

		// a completed read flips the byte phase, and keeps flipping on
		// every later read of the same result
		if (read_end) begin
			s_d.phase = !s_q.phase;
		end

		// a rising start always powers the converter up again
		if (start_rise) begin
			s_d.powered = 1'b1;
		end

		case (s_q.st)
			SACC_ST_TRACK: begin
				// a gated fall while tracking starts a conversion
				if (gated_fall) begin
					s_d.st       = SACC_ST_CONV;
					s_d.conv_cnt = CONV_LAST_C;
					s_d.phase    = 1'b0;
				end
			end
			SACC_ST_CONV: begin
				// a gated fall here is ignored: no restart mid-conversion
				if (conv_done) begin
					s_d.st      = SACC_ST_TRACK;
					// straight binary: the code is stored as delivered
					s_d.result  = SAR_CODE;
					s_d.fast    = CONVERT_START_N;
					// pin level at busy fall picks the power mode
					s_d.powered = CONVERT_START_N || start_rise;
				end else begin
					s_d.conv_cnt = s_q.conv_cnt - 10'h001;
				end
			end
			default: begin
				s_d.st = SACC_ST_TRACK;
			end
		endcase

		// data register follows the next phase so a back-to-back read
		// never sees the byte of the previous one
		if (s_d.phase) begin
			s_d.db = {s_d.result[LSB_N-1:0], {LSB_PAD_W{1'b0}}};
		end else begin
			s_d.db = s_d.result[RES_W-1:MSB_LO_POS];
		end
	end

	// ==================================================================
	// state register; powered stays low after reset
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			s_q          <= '0;
			s_q.st       <= SACC_ST_TRACK;
			s_q.conv_cnt <= CNT_RST;
			s_q.result   <= RESULT_RST;
			s_q.db       <= DB_RST;
			s_q.powered  <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	// ==================================================================
	// outputs; the read port ignores the power state on purpose
	always_comb begin
		rd.data = s_q.db;
		rd.oe   = access;
	end

	assign DB_O      = rd.data;
	assign DB_OE     = rd.oe;
	assign BUSY      = (s_q.st == SACC_ST_CONV);
	assign HOLD      = (s_q.st == SACC_ST_CONV);
	assign POWERED   = s_q.powered;
	assign FAST_MODE = s_q.fast;

	// ==================================================================
	// checks
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);

	// helper counters: length of the present busy and pulse runs
	logic [CNT_W-1:0] busy_run;
	logic [CNT_W-1:0] pls_run;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			busy_run <= CNT_RST;
			pls_run  <= CNT_RST;
		end else begin
			busy_run <= BUSY ? busy_run + 10'h001 : CNT_RST;
			pls_run  <= pls_act ? pls_run + 10'h001 : CNT_RST;
		end
	end

	sequence s_start_rise;
		$rose(CONVERT_START_N);
	endsequence

	sequence s_pulse_on;
		pls_act;
	endsequence

	busy_length_a: assert property ($fell(BUSY) |-> busy_run == CONV_CYCLES)
		else $error("busy did not last the conversion time");

	pulse_length_a: assert property ($fell(pls_act) |-> pls_run == PUP_CYCLES)
		else $error("power-up pulse has wrong length");

	pulse_start_a: assert property (s_start_rise |=> s_pulse_on)
		else $error("rising start gave no power-up pulse");

	conv_start_a: assert property (!BUSY && $fell(gated) |=> BUSY && HOLD)
		else $error("gated fall did not start a conversion");

	late_start_a: assert property (
		!BUSY && CONVERT_START_N && $fell(pls_act) |=> !BUSY)
		else $error("conversion started while start pin high");

	no_restart_a: assert property (
		BUSY && $fell(gated) && !conv_done |=> s_q.conv_cnt == $past(s_q.conv_cnt) - 10'h001)
		else $error("conversion restarted while busy");

	end_latch_a: assert property (
		$fell(BUSY) |-> !HOLD && s_q.result == $past(SAR_CODE))
		else $error("result not latched at end of conversion");

	mode_pick_a: assert property (
		$fell(BUSY) && !$past(start_rise) |-> POWERED == $past(CONVERT_START_N)
			&& FAST_MODE == $past(CONVERT_START_N))
		else $error("power mode does not follow start pin at busy fall");

	power_up_a: assert property (s_start_rise |=> POWERED)
		else $error("rising start did not power up");

	phase_reset_a: assert property ($rose(BUSY) |-> !s_q.phase)
		else $error("read phase not reset at busy rise");

	read_flip_a: assert property (
		read_end && !(s_q.st == SACC_ST_TRACK && gated_fall) |=> s_q.phase != $past(s_q.phase))
		else $error("read phase did not alternate");

	low_byte_a: assert property (
		DB_OE && s_q.phase |-> DB_O == {s_q.result[1:0], 6'h00})
		else $error("low-bits read has wrong layout");

	high_byte_a: assert property (
		DB_OE && !s_q.phase && !$past(read_end) |-> DB_O == s_q.result[9:2])
		else $error("upper-byte read has wrong data");

	drive_gate_a: assert property (
		(CS_N || RD_N) |-> !DB_OE)
		else $error("data driven without select and strobe");

	sleep_read_a: assert property (
		!POWERED && !CS_N && !RD_N |-> DB_OE)
		else $error("read port dead while powered down");

	// ==================================================================
	// start timing, power state and read port stability
	// the first two watch the step from a start condition to a fresh conversion,
	// so a slip of one cycle in the gating shows up here first

	// pulse runs out while the pin already sits low
	sequence s_pulse_end_low;
		!BUSY && !CONVERT_START_N && $fell(pls_act);
	endsequence

	// pin falls after the pulse has run out
	sequence s_pin_fall_late;
		!BUSY && !pls_act && $fell(CONVERT_START_N);
	endsequence

	// a freshly started conversion: hold on, read order back at the top
	sequence s_conv_fresh;
		BUSY && HOLD && !s_q.phase && s_q.conv_cnt == CONV_LAST_C;
	endsequence

	early_start_a: assert property (s_pulse_end_low |=> s_conv_fresh)
		else $error("pin low at pulse end gave no conversion");

	pin_start_a: assert property (s_pin_fall_late |=> s_conv_fresh)
		else $error("late pin fall gave no conversion");

	busy_keep_a: assert property (BUSY && !conv_done |=> BUSY)
		else $error("busy dropped before the conversion ended");

	result_keep_a: assert property (!$fell(BUSY) |-> $stable(s_q.result))
		else $error("result changed away from a busy fall");

	fast_keep_a: assert property (!$fell(BUSY) |-> $stable(FAST_MODE))
		else $error("mode changed away from a busy fall");

	// only a rising start may wake the converter once it sleeps
	stay_down_a: assert property (!POWERED && !start_rise |=> !POWERED)
		else $error("converter woke without a rising start");

	read_steady_a: assert property (DB_OE && $past(DB_OE) |-> $stable(DB_O))
		else $error("read data moved during a read");

endmodule

/* File: test/sacc_host.sv */
// sacc_host: behavioural host processor that drives convert start and the read strobes.
// assumes the converter shares CLK and answers reads combinationally on its data port.
`timescale 1ns/1ps
module sacc_host
	import sacc_pkg::*;
#(
	parameter int IDLE_CYC = 26
) (
	// clock
	input  wire logic             clk,
	// converter status and data
	input  wire logic             busy,
	input  wire logic [BUS_W-1:0] db,
	input  wire logic             db_oe,
	// host strobes
	output logic                  convert_start_n,
	output logic                  cs_n,
	output logic                  rd_n
);
	// ==================================================================
	// idle levels: pin low so power-up does not fire during reset
	initial begin
		convert_start_n = 1'b0;
		cs_n            = 1'b1;
		rd_n            = 1'b1;
	end

	// ==================================================================
	// start: from low, rise then fall after hi_cyc edges; from high, fall now
	task automatic start(input int hi_cyc, output int n);
		// a long quiet gap keeps reads clear of the next falling edge
		repeat (IDLE_CYC) @(posedge clk);
		#1;
		n = 0;
		convert_start_n = !convert_start_n;
		while (n < 300 && busy !== 1'b1) begin
			@(posedge clk);
			#1;
			n++;
			if (n == hi_cyc) begin
				convert_start_n = 1'b0;
			end
		end
	endtask

	// plain pin move, used while a conversion runs; the level left at
	// busy fall is the host's mode pick, high for fast sampling
	task automatic set_pin(input logic v);
		convert_start_n = v;
	endtask

	// one read cycle; only called with busy low
	task automatic read(output logic [BUS_W-1:0] d, output logic oe);
		@(posedge clk);
		#1;
		cs_n = 1'b0;
		rd_n = 1'b0;
		@(posedge clk);
		#1;
		d    = db;
		oe   = db_oe;
		cs_n = 1'b1;
		rd_n = 1'b1;
	endtask
endmodule

/* File: test/tb_sacc_ctrl.sv */
// tb_sacc_ctrl: self-checking bench for the converter control and its two-read port.
// assumes short counts (conversion 8, power-up 4 cycles) stand in for the real times.
`timescale 1ns/1ps
module tb_sacc_ctrl;
	import sacc_pkg::*;
	localparam int CONV_N = 8;
	localparam int PUP_N  = 4;

	logic             clk;
	logic             rst;
	logic [RES_W-1:0] sar_code;
	logic             busy;
	logic             hold;
	logic             powered;
	logic             fast_mode;
	logic             db_oe;
	logic [BUS_W-1:0] db;
	logic             cst_n;
	logic             cs_n;
	logic             rd_n;
	logic [RES_W-1:0] exp_code;
	logic [BUS_W-1:0] byte_q[$];
	int               err_total;
	int               samples_checked;

	// ==================================================================
	// design and host
	sacc_ctrl #(.CONV_CYCLES(CONV_N), .PUP_CYCLES(PUP_N)) dut_u (
		.CLK(clk), .RST(rst), .CONVERT_START_N(cst_n), .BUSY(busy), .HOLD(hold),
		.POWERED(powered), .FAST_MODE(fast_mode), .SAR_CODE(sar_code), .CS_N(cs_n),
		.RD_N(rd_n), .DB_O(db), .DB_OE(db_oe));
	sacc_host host_u (.clk(clk), .busy(busy), .db(db), .db_oe(db_oe),
		.convert_start_n(cst_n), .cs_n(cs_n), .rd_n(rd_n));

	always #2 clk = ~clk;

	// ==================================================================
	// checking and closing
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wrap_up();
		if (err_total == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// reads compared with the model's byte order
	task automatic read_chk(input int count);
		logic [BUS_W-1:0] d;
		logic             oe;
		logic [BUS_W-1:0] e;
		for (int i = 0; i < count; i++) begin
			host_u.read(d, oe);
			// the model's two bytes rotate, so reads keep alternating
			e = byte_q.pop_front();
			byte_q.push_back(e);
			chk(d, e);
			chk(oe, 1'b1);
			// look at the enable once the released strobes have settled
			@(posedge clk);
			#1;
			chk(db_oe, 1'b0);
		end
	endtask

	// one conversion: start window, busy length, mode at the end, then reads
	task automatic convert(input int hi_cyc, input logic end_hi, input logic glitch,
		input int reads);
		int               n;
		int               lo;
		logic [RES_W-1:0] code;
		code     = RES_W'($urandom);
		sar_code = code;
		lo       = 1;
		if (cst_n === 1'b0) begin
			lo = ((hi_cyc > PUP_N) ? hi_cyc : PUP_N) + 1;
		end
		host_u.start(hi_cyc, n);
		chk(n >= lo && n <= lo + 2, 1'b1);
		if (n >= 300) begin
			wrap_up();
		end
		chk(hold, 1'b1);
		chk(powered, 1'b1);
		// glitch: a second start edge rises inside this conversion; its fall lands there too only when end_hi is low
		if (glitch) begin
			host_u.set_pin(1'b1);
		end
		n = 1;
		while (n < 1000) begin
			@(posedge clk);
			#1;
			if (busy !== 1'b1) begin
				break;
			end
			n++;
			if (n == 2) begin
				host_u.set_pin(end_hi);
			end
		end
		chk(n, CONV_N);
		if (n >= 1000) begin
			wrap_up();
		end
		chk(hold, 1'b0);
		chk(powered, end_hi);
		chk(fast_mode, end_hi);
		exp_code = code;
		// busy rise put the read order back to the upper byte
		byte_q   = '{exp_code[9:2], {exp_code[1:0], 6'h00}};
		if (glitch) begin
			repeat (10) begin
				@(posedge clk);
				#1;
				chk(busy, 1'b0);
			end
		end
		read_chk(reads);
	endtask

	// ==================================================================
	// main sequence
	initial begin
		clk             = 1'b0;
		rst             = 1'b1;
		sar_code        = RESULT_RST;
		exp_code        = RESULT_RST;
		byte_q          = '{exp_code[9:2], {exp_code[1:0], 6'h00}};
		err_total       = 0;
		samples_checked = 0;
		void'($urandom(32'h6872507D));
		repeat (6) @(posedge clk);
		#1;
		rst = 1'b0;
		@(posedge clk);
		#1;
		chk(busy, 1'b0);
		chk(powered, 1'b0);
		read_chk(1);
		// short start pulse, power down after
		convert(1, 1'b0, 1'b0, 3);
		// start held past the pulse, stay powered after
		convert(10, 1'b1, 1'b0, 2);
		// fast-mode start from a high pin, one read leaves the low phase pending
		convert(0, 1'b1, 1'b0, 1);
		// second start edge during busy must not restart
		convert(0, 1'b0, 1'b1, 2);
		for (int i = 0; i < 8; i++) begin
			convert(1 + $urandom % 9, 1'($urandom), 1'($urandom), 1 + $urandom % 3);
		end
		wrap_up();
	end
endmodule
